// *** rtl/status_word_top.sv ***
/*
 Status word and auxiliary control register with data pointer selection.
 Assumes the core presents one SFR access per cycle on the core clock,
 and a one-cycle machine-cycle enable pulse for the increment timing.
*/
`timescale 1ns/1ps
`include "status_word_regs.svh"

// Behaviour
// - Increment of aux register toggles pointer select
// - Increment is two bytes, six machine cycles
// - Status bit 7 holds ALU carry
// - Status bit 6 holds half carry
// - Status bit 5 free user flag
// - Status bits 4-3 select register bank
// - Status bit 2 set on signed overflow
// - Status bit 1 second free user flag
// - Status bit 0 shows accumulator odd parity
// - Status word resets to all zeros
// - Aux bits 7-6 undefined, never written one
// - Bank field maps banks to 8-byte windows
// - Select bit picks physical pointer zero or one
// - Aux bit 2 reads zero, ignores writes
// - Both pointers share high and low addresses
module status_word_top
    import status_word_pkg::*;
(
    input  wire logic         I_CLOCK,
    input  wire logic         I_RESETN,
    input  wire logic         I_MCYCLE_EN,
    input  wire logic [7:0]   I_SFR_ADDR,
    input  wire logic         I_SFR_WR,
    input  wire logic         I_SFR_RD,
    input  wire logic [7:0]   I_SFR_WDATA,
    input  wire logic         I_SFR_INC,
    input  wire logic         I_DATA_POINTER_INC,
    input  wire logic         I_ALU_FLAG_WE,
    input  wire logic         I_ALU_CARRY,
    input  wire logic         I_ALU_HALF_CARRY,
    input  wire logic         I_ALU_OVERFLOW,
    input  wire logic [7:0]   I_ACCUMULATOR,
    output logic [7:0]        O_SFR_RDATA,
    output logic              O_SFR_RVALID,
    output logic [7:0]        O_PROGRAM_STATUS_WORD,
    output logic [7:0]        O_AUXILIARY_CONTROL_ONE,
    output logic [1:0]        O_BANK_SELECT,
    output logic [7:0]        O_BANK_BASE,
    output logic              O_POINTER_SELECT,
    output logic [15:0]       O_DATA_POINTER,
    output logic              O_INC_BUSY,
    output logic              O_INC_DONE
);
    typedef struct packed {
        byte_t      status;
        logic       sel;
        logic [1:0] aux_hi;
        inc_state_e inc_st;
        logic [2:0] mcnt;
        byte_t      rdata;
        logic       rvalid;
        logic [7:0] bank_base;
        ptr_t       data_pointer;
        logic       done;
    } top_state_s;

    top_state_s st_ff;
    top_state_s nxt_st;
    pointer_if  pif();

    function automatic logic odd_parity(input byte_t v);
        return ^v;
    endfunction

    function automatic byte_t aux_view(input logic sel);
        byte_t v;
        v = 8'h00;
        v[`AUX1_SEL_BIT] = sel;
        v[`AUX1_ZERO_BIT] = 1'b0;
        return v;
    endfunction

    function automatic logic hit(input byte_t a, input byte_t b);
        return a == b;
    endfunction

    logic inc_aux;

    assign inc_aux = I_SFR_INC && hit(I_SFR_ADDR, `AUX1_ADDR) && st_ff.inc_st == ST_IDLE;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rvalid = 1'b0;
        nxt_st.done = 1'b0;
        // Hardware flag updates first; a software write in the same cycle wins
        if (I_ALU_FLAG_WE) begin
            nxt_st.status[`STATUS_CARRY_BIT] = I_ALU_CARRY;
            nxt_st.status[`STATUS_HALF_BIT] = I_ALU_HALF_CARRY;
            nxt_st.status[`STATUS_OVF_BIT] = I_ALU_OVERFLOW;
        end
        if (I_SFR_WR && hit(I_SFR_ADDR, `STATUS_ADDR)) begin
            nxt_st.status = I_SFR_WDATA;
        end
        // Parity is never stored from software; it tracks the accumulator
        nxt_st.status[`STATUS_PAR_BIT] = odd_parity(I_ACCUMULATOR);
        if (I_SFR_WR && hit(I_SFR_ADDR, `AUX1_ADDR)) begin
            nxt_st.sel = I_SFR_WDATA[`AUX1_SEL_BIT];
            nxt_st.aux_hi = 2'b00;
        end
        // Six machine cycle increment; select flips at the end
        case (st_ff.inc_st)
            ST_IDLE: begin
                if (inc_aux) begin
                    nxt_st.inc_st = ST_BUSY;
                    nxt_st.mcnt = 3'(`INC_MACH_CYCLES - 1);
                end
            end
            ST_BUSY: begin
                if (I_MCYCLE_EN) begin
                    if (st_ff.mcnt == 3'h0) begin
                        nxt_st.sel = ~st_ff.sel;
                        nxt_st.inc_st = ST_DONE;
                    end else begin
                        nxt_st.mcnt = 3'(st_ff.mcnt - 3'h1);
                    end
                end
            end
            ST_DONE: begin
                nxt_st.done = 1'b1;
                nxt_st.inc_st = ST_IDLE;
            end
            default: begin
                nxt_st.inc_st = ST_IDLE;
            end
        endcase
        nxt_st.bank_base = {3'h0, nxt_st.status[`STATUS_BANK_HI:`STATUS_BANK_LO], 3'h0};
        nxt_st.data_pointer = pif.ptr;
        if (I_SFR_RD) begin
            nxt_st.rvalid = 1'b1;
            if (hit(I_SFR_ADDR, `STATUS_ADDR)) begin
                // Stored parity bit is already the previous cycle's accumulator parity
                nxt_st.rdata = st_ff.status;
            end else if (hit(I_SFR_ADDR, `AUX1_ADDR)) begin
                nxt_st.rdata = aux_view(st_ff.sel);
            end else if (hit(I_SFR_ADDR, `PTR_HI_ADDR)) begin
                nxt_st.rdata = pif.ptr[15:8];
            end else if (hit(I_SFR_ADDR, `PTR_LO_ADDR)) begin
                nxt_st.rdata = pif.ptr[7:0];
            end else begin
                nxt_st.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RESETN) begin
            st_ff <= '{status: `STATUS_RESET, sel: 1'b0, aux_hi: 2'b00, inc_st: ST_IDLE,
                       mcnt: 3'h0, rdata: 8'h00, rvalid: 1'b0, bank_base: 8'h00,
                       data_pointer: 16'h0000, done: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pif.sel = st_ff.sel;
    assign pif.wr_hi = I_SFR_WR && hit(I_SFR_ADDR, `PTR_HI_ADDR);
    assign pif.wr_lo = I_SFR_WR && hit(I_SFR_ADDR, `PTR_LO_ADDR);
    assign pif.inc = I_DATA_POINTER_INC;
    assign pif.wdata = I_SFR_WDATA;

    dual_pointer u_pointers (
        .i_clock  (I_CLOCK),
        .i_resetn (I_RESETN),
        .pif      (pif.bank)
    );

    assign O_SFR_RDATA = st_ff.rdata;
    assign O_SFR_RVALID = st_ff.rvalid;
    assign O_PROGRAM_STATUS_WORD = st_ff.status;
    assign O_AUXILIARY_CONTROL_ONE = {st_ff.aux_hi, 5'h00, st_ff.sel};
    assign O_BANK_SELECT = st_ff.status[`STATUS_BANK_HI:`STATUS_BANK_LO];
    assign O_BANK_BASE = st_ff.bank_base;
    assign O_POINTER_SELECT = st_ff.sel;
    assign O_DATA_POINTER = st_ff.data_pointer;
    // One-hot code: the busy state is a single flop, no decode on the pin
    assign O_INC_BUSY = st_ff.inc_st[1];
    assign O_INC_DONE = st_ff.done;
endmodule

// *** rtl/status_word_regs.svh ***
/*
 Register offsets, field positions, reset values and timing counts for the
 status word and pointer select block. Assumes one include per compile unit.
*/
`ifndef STATUS_WORD_REGS_SVH
`define STATUS_WORD_REGS_SVH

`define STATUS_ADDR       8'h8e
`define AUX1_ADDR         8'ha2
`define PTR_HI_ADDR       8'h83
`define PTR_LO_ADDR       8'h84
`define STATUS_CARRY_BIT  7
`define STATUS_HALF_BIT   6
`define STATUS_UF0_BIT    5
`define STATUS_BANK_HI    4
`define STATUS_BANK_LO    3
`define STATUS_OVF_BIT    2
`define STATUS_UF1_BIT    1
`define STATUS_PAR_BIT    0
`define AUX1_SEL_BIT      0
`define AUX1_ZERO_BIT     2
`define STATUS_RESET      8'h00
`define AUX1_RESET        8'h00
`define AUX1_RSVD_MASK    8'hc0
`define INC_CODE_BYTES    2
`define INC_MACH_CYCLES   6
`define BANK_BYTES        8'h08

`endif

// *** rtl/status_word_pkg.sv ***
/*
 Types shared by the status word block and its pointer bank.
 Assumes the matching _regs.svh header supplies the numbers.
*/
package status_word_pkg;
    typedef logic [7:0]  byte_t;
    typedef logic [15:0] ptr_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BUSY = 3'b010,
        ST_DONE = 3'b100
    } inc_state_e;
endpackage

// *** rtl/pointer_if.sv ***
/*
 Carrier between the register block and the dual pointer bank.
 Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
interface pointer_if;
    logic                       sel;
    logic                       wr_hi;
    logic                       wr_lo;
    logic                       inc;
    logic [7:0]                 wdata;
    logic [15:0]                ptr;
    modport ctrl (output sel, output wr_hi, output wr_lo, output inc, output wdata, input ptr);
    modport bank (input sel, input wr_hi, input wr_lo, input inc, input wdata, output ptr);
endinterface

// *** rtl/dual_pointer.sv ***
/*
 Two physical data pointers behind one architectural view.
 Assumes write strobes are one-cycle pulses on the core clock.
*/
`timescale 1ns/1ps
module dual_pointer
    import status_word_pkg::*;
(
    input  wire logic    i_clock,
    input  wire logic    i_resetn,
    pointer_if.bank      pif
);
    typedef struct packed {
        ptr_t p0;
        ptr_t p1;
    } ptr_state_s;

    ptr_state_s st_ff;
    ptr_state_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        // Only the selected pointer is touched
        if (pif.sel == 1'b0) begin
            if (pif.wr_hi) nxt_st.p0[15:8] = pif.wdata;
            if (pif.wr_lo) nxt_st.p0[7:0] = pif.wdata;
            if (pif.inc) nxt_st.p0 = 16'(st_ff.p0 + 16'h0001);
        end else begin
            if (pif.wr_hi) nxt_st.p1[15:8] = pif.wdata;
            if (pif.wr_lo) nxt_st.p1[7:0] = pif.wdata;
            if (pif.inc) nxt_st.p1 = 16'(st_ff.p1 + 16'h0001);
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) st_ff <= '0;
        else st_ff <= nxt_st;
    end

    assign pif.ptr = pif.sel ? st_ff.p1 : st_ff.p0;
endmodule

// *** verification/status_word_asserts.sv ***
/* Port checker for the status word and pointer select block.
 Assumes one core clock and the sync active-low reset. */
`timescale 1ns/1ps
module status_word_asserts (
    input wire logic       I_CLOCK,
    input wire logic       I_RESETN,
    input wire logic       I_MCYCLE_EN,
    input wire logic [7:0] I_SFR_ADDR,
    input wire logic       I_SFR_WR,
    input wire logic       I_SFR_RD,
    input wire logic [7:0] I_SFR_WDATA,
    input wire logic       I_SFR_INC,
    input wire logic       I_ALU_FLAG_WE,
    input wire logic       I_ALU_CARRY,
    input wire logic       I_ALU_HALF_CARRY,
    input wire logic       I_ALU_OVERFLOW,
    input wire logic [7:0] I_ACCUMULATOR,
    input wire logic [7:0] O_SFR_RDATA,
    input wire logic       O_SFR_RVALID,
    input wire logic [7:0] O_PROGRAM_STATUS_WORD,
    input wire logic [7:0] O_AUXILIARY_CONTROL_ONE,
    input wire logic [1:0] O_BANK_SELECT,
    input wire logic [7:0] O_BANK_BASE,
    input wire logic       O_POINTER_SELECT,
    input wire logic       O_INC_BUSY,
    input wire logic       O_INC_DONE
);
    logic       busy_q_ff;
    logic [2:0] mcnt_ff;
    logic       sel_ff;
    // Cycle right after busy falls is the settling state that ignores a new increment
    wire logic  start = I_SFR_INC && I_SFR_ADDR == 8'ha2 && !O_INC_BUSY && !busy_q_ff;
    always_ff @(posedge I_CLOCK) begin
        busy_q_ff <= I_RESETN && O_INC_BUSY;
        mcnt_ff <= (!I_RESETN || !O_INC_BUSY) ? 3'h0 : mcnt_ff + {2'h0, I_MCYCLE_EN};
        sel_ff <= start ? O_POINTER_SELECT : sel_ff;
    end
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESETN);
    sequence inc_start;
        start;
    endsequence
    sequence inc_finish;
        mcnt_ff == 3'h6 ##1 O_INC_DONE;
    endsequence
    aux_read_a: assert property (I_SFR_RD && !I_SFR_WR && I_SFR_ADDR == 8'ha2 |=>
        O_SFR_RVALID && O_SFR_RDATA == {7'h00, $past(O_POINTER_SELECT)}) else $error("aux read wrong");
    user_write_a: assert property (I_SFR_WR && I_SFR_ADDR == 8'h8e |=>
        (O_PROGRAM_STATUS_WORD | 8'h01) == ($past(I_SFR_WDATA) | 8'h01)) else $error("status write lost");
    alu_flags_a: assert property (I_ALU_FLAG_WE && !(I_SFR_WR && I_SFR_ADDR == 8'h8e) |=>
        O_PROGRAM_STATUS_WORD[7] == $past(I_ALU_CARRY) && O_PROGRAM_STATUS_WORD[6] == $past(I_ALU_HALF_CARRY)
        && O_PROGRAM_STATUS_WORD[2] == $past(I_ALU_OVERFLOW)) else $error("alu flags not loaded");
    parity_track_a: assert property ($past(I_RESETN) |->
        O_PROGRAM_STATUS_WORD[0] == ^$past(I_ACCUMULATOR)) else $error("parity wrong");
    bank_map_a: assert property (O_BANK_SELECT == O_PROGRAM_STATUS_WORD[4:3] &&
        O_BANK_BASE == {3'h0, O_BANK_SELECT, 3'h0}) else $error("bank base wrong");
    aux_view_a: assert property (O_AUXILIARY_CONTROL_ONE == {7'h00, O_POINTER_SELECT})
        else $error("aux view wrong");
    reset_clear_a: assert property ($rose(I_RESETN) |->
        O_PROGRAM_STATUS_WORD == 8'h00 && O_AUXILIARY_CONTROL_ONE == 8'h00) else $error("reset not clear");
    inc_busy_a: assert property (inc_start |=> O_INC_BUSY) else $error("increment not started");
    inc_count_a: assert property ($fell(O_INC_BUSY) |-> inc_finish) else $error("count not six");
    inc_toggle_a: assert property (O_INC_DONE |-> O_POINTER_SELECT != sel_ff)
        else $error("select not toggled");
endmodule
bind status_word_top status_word_asserts i_status_word_asserts (.I_CLOCK, .I_RESETN, .I_MCYCLE_EN,
    .I_SFR_ADDR, .I_SFR_WR, .I_SFR_RD, .I_SFR_WDATA, .I_SFR_INC, .I_ALU_FLAG_WE, .I_ALU_CARRY,
    .I_ALU_HALF_CARRY, .I_ALU_OVERFLOW, .I_ACCUMULATOR, .O_SFR_RDATA, .O_SFR_RVALID, .O_PROGRAM_STATUS_WORD,
    .O_AUXILIARY_CONTROL_ONE, .O_BANK_SELECT, .O_BANK_BASE, .O_POINTER_SELECT, .O_INC_BUSY, .O_INC_DONE);

// *** verification/tb.sv ***
/* Self-checking bench for the status word block.
 Assumes the checker file is compiled with it. */
`timescale 1ns/1ps
module tb import status_word_pkg::*; ;
    typedef struct {byte_t a, d, accum, rd, base;} row_s;
    logic  clk = 0, rstn = 0, mcy = 0, wr = 0, rd = 0, inc = 0, dinc = 0, fwe = 0, carry = 0, hc = 0, ovf = 0;
    logic  rv, sel, busy, done, exp;
    byte_t addr = 0, wd = 0, accum = 0, rdat, status, aux, base;
    logic [1:0] bank;
    ptr_t  dp;
    int    err_count = 0, check_count = 0, n;
    row_s  rows[7] = '{'{8'ha2, 8'h3f, 8'h00, 8'h01, 8'h00}, '{8'ha2, 8'h00, 8'h00, 8'h00, 8'h00},
        '{8'h55, 8'hff, 8'h00, 8'h00, 8'h00}, '{8'h8e, 8'h08, 8'h01, 8'h09, 8'h08},
        '{8'h8e, 8'h10, 8'h03, 8'h10, 8'h10}, '{8'h8e, 8'h19, 8'h07, 8'h19, 8'h18},
        '{8'h8e, 8'he6, 8'hff, 8'he6, 8'h00}};
    status_word_top i_status_word_top (.I_CLOCK(clk), .I_RESETN(rstn), .I_MCYCLE_EN(mcy), .I_SFR_ADDR(addr),
        .I_SFR_WR(wr), .I_SFR_RD(rd), .I_SFR_WDATA(wd), .I_SFR_INC(inc), .I_DATA_POINTER_INC(dinc),
        .I_ALU_FLAG_WE(fwe), .I_ALU_CARRY(carry), .I_ALU_HALF_CARRY(hc), .I_ALU_OVERFLOW(ovf),
        .I_ACCUMULATOR(accum), .O_SFR_RDATA(rdat), .O_SFR_RVALID(rv), .O_PROGRAM_STATUS_WORD(status),
        .O_AUXILIARY_CONTROL_ONE(aux), .O_BANK_SELECT(bank), .O_BANK_BASE(base), .O_POINTER_SELECT(sel),
        .O_DATA_POINTER(dp), .O_INC_BUSY(busy), .O_INC_DONE(done));
    always #12.5 clk = ~clk;
    task cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task sfr(input byte_t a, input byte_t d, input logic w);
        // Idle edge first, so a strobe never drops and rises in one step
        cyc(1);
        {addr, wd, wr, rd} = {a, d, w, !w};
        cyc(1);
        {wr, rd} = 2'b00;
    endtask
    task chk(input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #(25 * 3000);
        err_count++;
        wrap_up;
    end
    initial begin
        cyc(16);
        rstn = 1;
        cyc(1);
        chk({status, aux}, 16'h0000);
        foreach (rows[i]) begin
            accum = rows[i].accum;
            sfr(rows[i].a, rows[i].d, 1);
            sfr(rows[i].a, 8'h00, 0);
            chk({7'h0, rv, rdat}, {8'h01, rows[i].rd});
            chk({6'h0, bank, base}, {6'h0, rows[i].base[4:3], rows[i].base});
        end
        {carry, hc, ovf, fwe} = 4'hf;
        sfr(8'h8e, 8'h00, 1);
        chk(status, 16'h0000);
        cyc(2);
        chk(status, 16'h00c4);
        {carry, hc, ovf} = 3'h0;
        cyc(1);
        chk(status, 16'h0000);
        fwe = 0;
        sfr(8'h83, 8'h12, 1);
        sfr(8'h84, 8'h34, 1);
        sfr(8'ha2, 8'h01, 1);
        sfr(8'h83, 8'hab, 1);
        sfr(8'h84, 8'hcd, 1);
        cyc(2);
        chk(dp, 16'habcd);
        sfr(8'ha2, 8'h00, 1);
        dinc = 1;
        cyc(1);
        dinc = 0;
        cyc(2);
        chk(dp, 16'h1235);
        {addr, inc} = {8'h8e, 1'b1};
        cyc(1);
        inc = 0;
        chk(busy, 0);
        repeat (2) begin
            exp = !sel;
            {addr, inc} = {8'ha2, 1'b1};
            cyc(1);
            inc = 0;
            chk(busy, 1);
            repeat (5) begin
                mcy = 1;
                cyc(1);
                mcy = 0;
                cyc(1);
            end
            inc = 1;
            cyc(1);
            inc = 0;
            chk({busy, sel}, {1'b1, !exp});
            mcy = 1;
            cyc(1);
            mcy = 0;
            for (n = 0; done !== 1'b1 && n < 8; n++)
                cyc(1);
            chk({done, sel}, {1'b1, exp});
            cyc(2);
            chk({done, busy}, 0);
        end
        sfr(8'h8e, 8'h3e, 1);
        rstn = 0;
        cyc(2);
        chk({status, aux}, 16'h0000);
        rstn = 1;
        cyc(2);
        chk({status, aux}, 16'h0000);
        sfr(8'ha2, 8'h00, 0);
        chk({7'h0, rv, rdat}, 16'h0100);
        wrap_up;
    end
endmodule
